//--- csrf_pkg.sv
// ****************************************************************
// Register map and field layout
// ****************************************************************
package csrf_pkg;

   localparam int unsigned CLK_MHZ = 200;

   // Data memory addresses
   localparam logic [5:0] ADDR_INDIRECT = 6'h00;
   localparam logic [5:0] ADDR_TIMER = 6'h01;
   localparam logic [5:0] ADDR_PCL = 6'h02;
   localparam logic [5:0] ADDR_STATUS = 6'h03;
   localparam logic [5:0] ADDR_POINTER = 6'h04;
   localparam logic [5:0] ADDR_PORT = 6'h06;
   localparam logic [5:0] ADDR_IRQ = 6'h0F;
   localparam logic [5:0] ADDR_RAM_LO = 6'h10;
   localparam logic [5:0] ADDR_RAM_HI = 6'h3F;
   localparam int unsigned RAM_WORDS = 48;

   // Program counter and vectors
   localparam int unsigned PC_W = 10;
   localparam logic [9:0] VEC_RESET = 10'h000;
   localparam logic [9:0] VEC_SW_INT = 10'h001;
   localparam logic [9:0] VEC_HW_INT = 10'h008;
   localparam logic [9:0] PC_ONE = 10'h001;
   localparam int unsigned STACK_DEPTH = 6;
   localparam logic [2:0] SP_LAST = 3'h5;
   localparam logic [2:0] SP_FIRST = 3'h0;

   // Status bit positions
   localparam int unsigned ST_CARRY = 0;
   localparam int unsigned ST_HALF = 1;
   localparam int unsigned ST_ZERO = 2;
   localparam int unsigned ST_SLEEP = 3;
   localparam int unsigned ST_WDT = 4;
   localparam int unsigned ST_PAGE = 5;
   localparam int unsigned ST_GP = 6;
   localparam int unsigned ST_WAKE = 7;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] STATUS_SW_MASK = 8'hE7;

   // Pointer: upper two bits read as one
   localparam logic [7:0] POINTER_FILL = 8'hC0;

   // Interrupt flag bit positions
   localparam int unsigned IF_TIMER = 0;
   localparam int unsigned IF_PORT = 1;
   localparam int unsigned IF_EXT = 2;
   localparam int unsigned IF_WDT = 6;
   localparam logic [7:0] IRQ_MASK = 8'h47;

   // Prescale mode fields
   localparam int unsigned MD_TARGET = 3;
   localparam int unsigned MD_EDGE = 4;
   localparam int unsigned MD_SOURCE = 5;
   localparam logic [7:0] MODE_RESET = 8'h3F;

   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam int unsigned SHARED_RESET_BIT = 3;

   // Result of one ALU operation
   typedef struct packed {
      logic update;
      logic sub;
      logic carry;
      logic half;
      logic [7:0] result;
   } csrf_alu_t;

   // Program flow request for one instruction cycle
   typedef struct packed {
      logic hw_int;
      logic sw_int;
      logic call;
      logic jump;
      logic ret;
      logic [9:0] target;
   } csrf_flow_t;

   // Register file access from the execution core
   typedef struct packed {
      logic rd;
      logic wr;
      logic mode_wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } csrf_access_t;

endpackage

//--- csrf_top.sv
`timescale 1ns/1ps
// Operation
// - Program counter is ten bits, addressing 1K words of program memory.
// - Reset fetches 000h, software interrupt goes to 001h, hardware to 008h.
// - Return-address stack holds six entries for calls and interrupts.
// - Ordinary instructions take one cycle, flow changes take two.
// - Registers sit at 00h,01h,02h,03h,04h,06h,0Fh; storage at 10h to 3Fh.
// - Address 00h has no storage and reaches the location the pointer selects.
// - Pointer low six bits select a location; upper two bits read one.
// - Timer counts pin edges or instruction cycles and is read/write.
// - PC low byte advances by one each sequential instruction cycle.
// - Writing PC low byte loads status bit 5 into A9, clears A8.
// - Carry set on add carry; on subtract set when no borrow.
// - Half carry follows the low nibble the same way.
// - Zero bit set for zero result, cleared otherwise.
// - Sleep flag set at power-up and watchdog clear, cleared by sleep.
// - Watchdog flag set at power-up, clear, sleep; cleared on timeout.
// - Status bit 5 preselects program page 000h-1FFh or 200h-3FFh.
// - Status bit 6 is general; bit 7 set on port-change wake.
// - Flags 0,1,2,6 set on timer, port, pin, watchdog; software clears.
// - Prescale mode is write-only; ratio field sets eight division scales.
// - Port data register at 06h reaches the eight port lines.
// - Selected shared reset pin held low holds the device, except RDATA_O, in reset.
// - Mode bit 5 picks timer source, bit 4 picks counted edge.
// - Mode bit 3 gives prescaler to timer when zero, watchdog when one.
module csrf_top
   import csrf_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   // Execution core
   input wire logic INSN_EN_I,
   input wire csrf_flow_t FLOW_I,
   input wire csrf_access_t ACCESS_I,
   input wire csrf_alu_t ALU_I,
   input wire logic SLEEP_I,
   input wire logic WDT_CLEAR_I,
   output logic [9:0] PC_O,
   output logic FETCH_BUBBLE_O,
   output logic [7:0] RDATA_O,
   output logic [7:0] STATUS_O,
   output logic [7:0] MODE_O,
   output logic [7:0] IRQ_FLAGS_O,
   output logic SLEEPING_O,
   // Pins and watchdog oscillator
   input wire logic [7:0] PORT_PIN_I,
   input wire logic TIMER_PIN_I,
   input wire logic EXT_INT_I,
   input wire logic SHARED_RESET_SEL_I,
   input wire logic WDT_TICK_I,
   input wire logic WDT_ENABLE_I,
   output logic [7:0] PORT_OUT_O,
   output logic WDT_RESET_O,
   output logic PIN_RESET_O
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0] ram [RAM_WORDS];
   logic [9:0] stack [STACK_DEPTH];
   logic [2:0] sp;
   logic [2:0] sp_prev;
   logic [7:0] timer;
   logic [7:0] pointer;
   logic [7:0] prescaler_target;
   logic [7:0] port_prev;
   logic tpin_prev;
   logic ext_prev;
   logic edge_armed;
   logic pin_hold;
   logic [5:0] eff_addr;
   logic do_wr;
   logic [7:0] rd_mux;
   logic flow_any;
   logic step;
   logic src_tick;
   logic psc_timer;
   logic [7:0] psc_next;
   logic [7:0] tmr_mask;
   logic [7:0] wrst_mask;
   logic [7:0] wirq_mask;
   logic timer_inc;
   logic timer_ovf;
   logic wdt_tick;
   logic wdt_rst_evt;
   logic wdt_irq_evt;
   logic port_chg;
   logic ext_evt;
   logic [7:0] next_irq;

   // ****************************************************************
   // Shared reset pin and addressing
   // ****************************************************************
   assign pin_hold = SHARED_RESET_SEL_I & ~PORT_PIN_I[SHARED_RESET_BIT];
   assign eff_addr = (ACCESS_I.addr == ADDR_INDIRECT) ? pointer[5:0] : ACCESS_I.addr;
   assign do_wr = ACCESS_I.wr & (eff_addr != ADDR_INDIRECT);
   assign flow_any = FLOW_I.hw_int | FLOW_I.sw_int | FLOW_I.call | FLOW_I.jump | FLOW_I.ret;
   assign step = INSN_EN_I & ~FETCH_BUBBLE_O;
   assign sp_prev = (sp == SP_FIRST) ? SP_LAST : sp - 3'h1;

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         PIN_RESET_O <= 1'b0;
      end else begin
         PIN_RESET_O <= pin_hold;
      end
   end

   // ****************************************************************
   // Program counter and stack
   // ****************************************************************
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         PC_O <= VEC_RESET;
         sp <= SP_FIRST;
         FETCH_BUBBLE_O <= 1'b0;
      end else if (pin_hold) begin
         PC_O <= VEC_RESET;
         sp <= SP_FIRST;
         FETCH_BUBBLE_O <= 1'b0;
      end else if (INSN_EN_I) begin
         FETCH_BUBBLE_O <= step & (flow_any | (do_wr & eff_addr == ADDR_PCL));
         if (step) begin
            if (FLOW_I.hw_int | FLOW_I.sw_int | FLOW_I.call) begin
               stack[sp] <= PC_O;
               sp <= (sp == SP_LAST) ? SP_FIRST : sp + 3'h1;
            end
            if (FLOW_I.hw_int) begin
               PC_O <= VEC_HW_INT;
            end else if (FLOW_I.sw_int) begin
               PC_O <= VEC_SW_INT;
            end else if (FLOW_I.call | FLOW_I.jump) begin
               PC_O <= FLOW_I.target;
            end else if (FLOW_I.ret) begin
               PC_O <= stack[sp_prev];
               sp <= sp_prev;
            end else if (do_wr && eff_addr == ADDR_PCL) begin
               PC_O <= {STATUS_O[ST_PAGE], 1'b0, ACCESS_I.wdata};
            end else begin
               PC_O <= PC_O + PC_ONE;
            end
         end
      end
   end

   // ****************************************************************
   // Status register
   // ****************************************************************
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         STATUS_O <= STATUS_RESET;
      end else if (pin_hold) begin
         STATUS_O <= STATUS_RESET;
      end else begin
         if (do_wr && eff_addr == ADDR_STATUS) begin
            STATUS_O <= (ACCESS_I.wdata & STATUS_SW_MASK) | (STATUS_O & ~STATUS_SW_MASK);
         end
         if (ALU_I.update) begin
            STATUS_O[ST_CARRY] <= ALU_I.sub ? ~ALU_I.carry : ALU_I.carry;
            STATUS_O[ST_HALF] <= ALU_I.sub ? ~ALU_I.half : ALU_I.half;
            STATUS_O[ST_ZERO] <= (ALU_I.result == BYTE_ZERO);
         end
         if (WDT_CLEAR_I) begin
            STATUS_O[ST_SLEEP] <= 1'b1;
            STATUS_O[ST_WDT] <= 1'b1;
         end else if (SLEEP_I) begin
            STATUS_O[ST_SLEEP] <= 1'b0;
            STATUS_O[ST_WDT] <= 1'b1;
         end
         if (wdt_rst_evt) begin
            STATUS_O[ST_WDT] <= 1'b0;
         end
         if (SLEEPING_O & port_chg) begin
            STATUS_O[ST_WAKE] <= 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         SLEEPING_O <= 1'b0;
      end else if (pin_hold) begin
         SLEEPING_O <= 1'b0;
      end else if (SLEEP_I) begin
         SLEEPING_O <= 1'b1;
      end else if (port_chg | ext_evt | wdt_rst_evt | wdt_irq_evt) begin
         SLEEPING_O <= 1'b0;
      end
   end

   // ****************************************************************
   // Pointer, port, mode and storage
   // ****************************************************************
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pointer <= POINTER_FILL;
         PORT_OUT_O <= BYTE_ZERO;
         MODE_O <= MODE_RESET;
      end else if (pin_hold) begin
         pointer <= POINTER_FILL;
         PORT_OUT_O <= BYTE_ZERO;
         MODE_O <= MODE_RESET;
      end else begin
         if (do_wr && eff_addr == ADDR_POINTER) begin
            pointer <= ACCESS_I.wdata | POINTER_FILL;
         end
         if (do_wr && eff_addr == ADDR_PORT) begin
            PORT_OUT_O <= ACCESS_I.wdata;
         end
         if (ACCESS_I.mode_wr) begin
            MODE_O <= ACCESS_I.wdata;
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (do_wr && eff_addr >= ADDR_RAM_LO) begin
         ram[eff_addr - ADDR_RAM_LO] <= ACCESS_I.wdata;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   always_comb begin
      rd_mux = BYTE_ZERO;
      unique case (eff_addr)
         ADDR_INDIRECT: rd_mux = BYTE_ZERO;
         ADDR_TIMER: rd_mux = timer;
         ADDR_PCL: rd_mux = PC_O[7:0];
         ADDR_STATUS: rd_mux = STATUS_O;
         ADDR_POINTER: rd_mux = pointer | POINTER_FILL;
         ADDR_PORT: rd_mux = PORT_PIN_I;
         ADDR_IRQ: rd_mux = IRQ_FLAGS_O & IRQ_MASK;
         default: begin
            if (eff_addr >= ADDR_RAM_LO) begin
               rd_mux = ram[eff_addr - ADDR_RAM_LO];
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RDATA_O <= BYTE_ZERO;
      end else if (ACCESS_I.rd) begin
         RDATA_O <= rd_mux;
      end
   end

   // ****************************************************************
   // Timer, prescaler and watchdog
   // ****************************************************************
   assign src_tick = MODE_O[MD_SOURCE] ?
      (edge_armed & (MODE_O[MD_EDGE] ? (tpin_prev & ~TIMER_PIN_I) : (~tpin_prev & TIMER_PIN_I)))
      : INSN_EN_I;
   assign psc_timer = ~MODE_O[MD_TARGET];
   assign wdt_tick = WDT_TICK_I & WDT_ENABLE_I;
   assign psc_next = prescaler_target + BYTE_ONE;
   assign tmr_mask = 8'((9'h002 << MODE_O[2:0]) - 9'h001);
   assign wrst_mask = 8'((9'h001 << MODE_O[2:0]) - 9'h001);
   assign wirq_mask = psc_timer ? BYTE_ONE : tmr_mask;
   assign timer_inc = src_tick & (~psc_timer | ((psc_next & tmr_mask) == BYTE_ZERO));
   assign wdt_rst_evt = wdt_tick & (psc_timer | ((psc_next & wrst_mask) == BYTE_ZERO));
   assign wdt_irq_evt = wdt_tick & ((psc_next & wirq_mask) == BYTE_ZERO);
   assign timer_ovf = timer_inc & (timer == BYTE_MAX) & ~(do_wr && eff_addr == ADDR_TIMER);

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         prescaler_target <= BYTE_ZERO;
      end else if (pin_hold) begin
         prescaler_target <= BYTE_ZERO;
      end else if (!psc_timer && WDT_CLEAR_I) begin
         prescaler_target <= BYTE_ZERO;
      end else if ((psc_timer & src_tick) | (~psc_timer & wdt_tick)) begin
         prescaler_target <= psc_next;
      end else if (psc_timer && wdt_tick) begin
         prescaler_target <= prescaler_target;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         timer <= BYTE_ZERO;
         tpin_prev <= 1'b0;
         WDT_RESET_O <= 1'b0;
      end else if (pin_hold) begin
         timer <= BYTE_ZERO;
         tpin_prev <= 1'b0;
         WDT_RESET_O <= 1'b0;
      end else begin
         tpin_prev <= TIMER_PIN_I;
         WDT_RESET_O <= wdt_rst_evt;
         if (do_wr && eff_addr == ADDR_TIMER) begin
            timer <= ACCESS_I.wdata;
         end else if (timer_inc) begin
            timer <= timer + BYTE_ONE;
         end
      end
   end

   // ****************************************************************
   // Interrupt flags
   // ****************************************************************
   assign port_chg = edge_armed & (PORT_PIN_I != port_prev);
   assign ext_evt = edge_armed & EXT_INT_I & ~ext_prev;

   always_comb begin
      next_irq = IRQ_FLAGS_O;
      if (do_wr && eff_addr == ADDR_IRQ) begin
         next_irq = ACCESS_I.wdata & IRQ_MASK;
      end
      next_irq[IF_TIMER] = next_irq[IF_TIMER] | timer_ovf;
      next_irq[IF_PORT] = next_irq[IF_PORT] | port_chg;
      next_irq[IF_EXT] = next_irq[IF_EXT] | ext_evt;
      next_irq[IF_WDT] = next_irq[IF_WDT] | wdt_irq_evt;
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         IRQ_FLAGS_O <= BYTE_ZERO;
         port_prev <= BYTE_ZERO;
         ext_prev <= 1'b0;
         edge_armed <= 1'b0;
      end else if (pin_hold) begin
         IRQ_FLAGS_O <= BYTE_ZERO;
         port_prev <= PORT_PIN_I;
         ext_prev <= 1'b0;
         edge_armed <= 1'b0;
      end else begin
         IRQ_FLAGS_O <= next_irq;
         port_prev <= PORT_PIN_I;
         ext_prev <= EXT_INT_I;
         edge_armed <= 1'b1;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!NRST_I || pin_hold);

   hw_vector_a: assert property (step && FLOW_I.hw_int |=> PC_O == VEC_HW_INT)
      else $error("hardware interrupt did not reach its vector");
   sw_vector_a: assert property (step && FLOW_I.sw_int && !FLOW_I.hw_int
      |=> PC_O == VEC_SW_INT)
      else $error("software interrupt did not reach its vector");
   call_return_a: assert property (step && FLOW_I.call
      && !FLOW_I.hw_int && !FLOW_I.sw_int ##1 !INSN_EN_I ##1 INSN_EN_I ##1 !INSN_EN_I
      ##1 (step && FLOW_I.ret && !FLOW_I.call && !FLOW_I.hw_int && !FLOW_I.sw_int
      && !FLOW_I.jump) |=> PC_O == $past(PC_O, 5))
      else $error("return did not restore the pushed address");
   flow_bubble_a: assert property (step && flow_any |=> FETCH_BUBBLE_O)
      else $error("flow change did not take a second cycle");
   seq_step_a: assert property (step && !flow_any && !(do_wr && eff_addr == ADDR_PCL)
      |=> PC_O == $past(PC_O) + PC_ONE)
      else $error("program counter did not advance");
   pcl_page_a: assert property (step && !flow_any && do_wr && eff_addr == ADDR_PCL
      |=> PC_O[9] == $past(STATUS_O[ST_PAGE]) && !PC_O[8])
      else $error("page bits wrong after low byte write");
   sub_carry_a: assert property (ALU_I.update && ALU_I.sub
      |=> STATUS_O[ST_CARRY] == !$past(ALU_I.carry))
      else $error("subtract carry sense wrong");
   zero_flag_a: assert property (ALU_I.update
      |=> STATUS_O[ST_ZERO] == ($past(ALU_I.result) == BYTE_ZERO))
      else $error("zero flag wrong");
   sleep_flag_a: assert property (SLEEP_I && !WDT_CLEAR_I && !wdt_rst_evt
      |=> !STATUS_O[ST_SLEEP] && STATUS_O[ST_WDT])
      else $error("sleep did not update power flags");
   wdt_flag_a: assert property (wdt_rst_evt |=> !STATUS_O[ST_WDT] && WDT_RESET_O)
      else $error("watchdog timeout not recorded");
   pointer_ones_a: assert property (ACCESS_I.rd && eff_addr == ADDR_POINTER
      |=> RDATA_O[7:6] == 2'h3)
      else $error("pointer upper bits not one");
   timer_ovf_a: assert property (timer_ovf
      |=> IRQ_FLAGS_O[IF_TIMER] && timer == BYTE_ZERO)
      else $error("timer overflow not flagged");
   flag_sticky_a: assert property (port_chg |=> IRQ_FLAGS_O[IF_PORT])
      else $error("port change flag lost");
   flag_unused_a: assert property ((IRQ_FLAGS_O & ~IRQ_MASK) == BYTE_ZERO)
      else $error("unused flag bit set");
   timer_count_a: assert property (timer_inc && !(do_wr && eff_addr == ADDR_TIMER)
      |=> timer == $past(timer) + BYTE_ONE)
      else $error("timer did not count");

endmodule // csrf_top

//--- csrf_core_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Execution core model
// ****************************************************************
module csrf_core_model
   import csrf_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Requests to the register file
   output logic insn_en_o,
   output csrf_flow_t flow_o,
   output csrf_access_t access_o,
   output csrf_alu_t alu_o,
   output logic sleep_o,
   output logic wdt_clear_o
);
   initial begin
      {insn_en_o, flow_o, access_o, alu_o, sleep_o, wdt_clear_o} = '0;
   end
   // One request, held until the edge that takes it, then released
   task automatic req(input logic en, input csrf_flow_t fl, input csrf_access_t ac,
      input csrf_alu_t al, input logic [1:0] pw);
      @(posedge clk_i);
      {insn_en_o, flow_o, access_o, alu_o} <= {en, fl, ac, al};
      {sleep_o, wdt_clear_o} <= pw;
      @(posedge clk_i);
      {insn_en_o, flow_o, access_o, alu_o, sleep_o, wdt_clear_o} <= '0;
   endtask
endmodule // csrf_core_model

//--- tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Testbench top
// ****************************************************************
module tb_top
   import csrf_pkg::*;
;
   logic clk, nrst, insn_en, sleep, wdt_clear, bubble, sleeping, wdt_rst, pin_rst, rd_taken;
   logic tmr_pin, ext_int, rst_sel, wdt_tick, wdt_en;
   csrf_flow_t flow;
   csrf_access_t acc;
   csrf_alu_t alu;
   logic [9:0] pc;
   logic [7:0] rdata, status, mode, irq, port_out, pins;
   logic [7:0] mem [16:63];
   logic [7:0] exp_q [$];
   logic [31:0] rng;
   int errors, checked;

   csrf_top i_dut (.REF_CLK_I(clk), .NRST_I(nrst), .INSN_EN_I(insn_en), .FLOW_I(flow),
      .ACCESS_I(acc), .ALU_I(alu), .SLEEP_I(sleep), .WDT_CLEAR_I(wdt_clear), .PC_O(pc),
      .FETCH_BUBBLE_O(bubble), .RDATA_O(rdata), .STATUS_O(status), .MODE_O(mode),
      .IRQ_FLAGS_O(irq), .SLEEPING_O(sleeping), .PORT_PIN_I(pins), .TIMER_PIN_I(tmr_pin),
      .EXT_INT_I(ext_int), .SHARED_RESET_SEL_I(rst_sel), .WDT_TICK_I(wdt_tick),
      .WDT_ENABLE_I(wdt_en), .PORT_OUT_O(port_out), .WDT_RESET_O(wdt_rst),
      .PIN_RESET_O(pin_rst));
   csrf_core_model i_core (.clk_i(clk), .insn_en_o(insn_en), .flow_o(flow), .access_o(acc),
      .alu_o(alu), .sleep_o(sleep), .wdt_clear_o(wdt_clear));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction
   task automatic chk(input logic [9:0] e, input logic [9:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic m);
      i_core.req(1'b0, '0, '{rd:1'b0, wr:~m, mode_wr:m, addr:a, wdata:d}, '0, 2'b00);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_core.req(1'b0, '0, '{rd:1'b1, wr:1'b0, mode_wr:1'b0, addr:a, wdata:8'h00}, '0, 2'b00);
   endtask
   task automatic step(input logic [4:0] f, input logic [9:0] t, input logic [7:0] pc_low_byte,
      input logic w, input logic [9:0] e);
      i_core.req(1'b1, {f, t}, '{rd:1'b0, wr:w, mode_wr:1'b0, addr:ADDR_PCL, wdata:pc_low_byte}, '0,
         2'b00);
      @(negedge clk);
      chk(e, pc);
      if (f != 5'h00 || w) begin
         chk(10'h001, {9'h000, bubble});
         i_core.req(1'b1, {5'h02, 10'h3FF}, '0, '0, 2'b00);
         @(negedge clk);
         chk(e, pc);
         chk(10'h000, {9'h000, bubble});
      end
   endtask
   task automatic alu_op(input logic s, c, h, input logic [7:0] r, e);
      i_core.req(1'b0, '0, '0, '{update:1'b1, sub:s, carry:c, half:h, result:r}, 2'b00);
      @(negedge clk);
      chk({2'h0, e}, {2'h0, status});
   endtask
   task automatic pin_pulse();
      @(posedge clk);
      tmr_pin <= 1'b1;
      repeat (4) @(posedge clk);
      tmr_pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic stop_test();
      if (exp_q.size() != 0) errors++;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****************************************************************
   // Clock, timeout and read monitor
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test();
   end
   always @(posedge clk) rd_taken <= acc.rd;
   always @(negedge clk) begin
      if (rd_taken === 1'b1 && exp_q.size() > 0) chk_rd(exp_q.pop_front(), rdata);
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rng = 32'd66;
      errors = 0;
      checked = 0;
      {nrst, tmr_pin, ext_int, rst_sel, wdt_tick, wdt_en} = '0;
      pins = 8'h08;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk(10'h018, {2'h0, status});
      chk(10'h03F, {2'h0, mode});
      chk(10'h000, pc);
      @(negedge clk);
      chk(10'h000, {2'h0, irq});
      wr(ADDR_POINTER, 8'h12, 1'b0);
      rd(ADDR_POINTER, 8'hD2);
      wr(ADDR_INDIRECT, 8'h55, 1'b0);
      rd(6'h12, 8'h55);
      rd(ADDR_INDIRECT, 8'h55);
      wr(6'h05, 8'hAA, 1'b0);
      rd(6'h05, 8'h00);
      for (int a = 16; a < 64; a++) begin
         mem[a] = rnd();
         wr(6'(a), mem[a], 1'b0);
      end
      for (int a = 16; a < 64; a++) rd(6'(a), mem[a]);
      wr(ADDR_STATUS, 8'hFF, 1'b0);
      rd(ADDR_STATUS, 8'hFF);
      wr(ADDR_STATUS, 8'h00, 1'b0);
      rd(ADDR_STATUS, 8'h18);
      alu_op(1'b0, 1'b1, 1'b1, 8'h00, 8'h1F);
      alu_op(1'b1, 1'b1, 1'b0, 8'h05, 8'h1A);
      alu_op(1'b1, 1'b0, 1'b1, 8'h80, 8'h19);
      step(5'h00, 10'h000, 8'h00, 1'b0, 10'h001);
      for (int i = 0; i < 6; i++) step(5'h04, 10'h040 + 10'(i), 8'h00, 1'b0, 10'h040 + 10'(i));
      for (int i = 5; i >= 0; i--)
         step(5'h01, 10'h000, 8'h00, 1'b0, (i == 0) ? 10'h001 : 10'h03F + 10'(i));
      step(5'h10, 10'h000, 8'h00, 1'b0, 10'h008);
      step(5'h08, 10'h000, 8'h00, 1'b0, 10'h001);
      step(5'h02, 10'h3FF, 8'h00, 1'b0, 10'h3FF);
      step(5'h00, 10'h000, 8'h00, 1'b0, 10'h000);
      step(5'h02, 10'h1FF, 8'h00, 1'b0, 10'h1FF);
      wr(ADDR_STATUS, 8'h20, 1'b0);
      step(5'h00, 10'h000, 8'h34, 1'b1, 10'h234);
      wr(ADDR_STATUS, 8'h00, 1'b0);
      step(5'h00, 10'h000, 8'h56, 1'b1, 10'h056);
      wr(ADDR_PORT, 8'hA5, 1'b0);
      @(negedge clk);
      chk(10'h0A5, {2'h0, port_out});
      @(posedge clk);
      pins <= 8'h3C;
      ext_int <= 1'b1;
      rd(ADDR_PORT, 8'h3C);
      @(negedge clk);
      chk(10'h006, {2'h0, irq & 8'h06});
      wr(6'h00, 8'h08, 1'b1);
      @(negedge clk);
      chk(10'h008, {2'h0, mode});
      wr(ADDR_TIMER, 8'hFE, 1'b0);
      step(5'h00, 10'h000, 8'h00, 1'b0, 10'h057);
      rd(ADDR_TIMER, 8'hFF);
      step(5'h00, 10'h000, 8'h00, 1'b0, 10'h058);
      rd(ADDR_TIMER, 8'h00);
      @(negedge clk);
      chk(10'h001, {9'h000, irq[0]});
      for (int ps = 0; ps < 3; ps++) begin
         wr(6'h00, 8'(ps), 1'b1);
         wr(ADDR_TIMER, 8'h00, 1'b0);
         repeat (2 << ps) i_core.req(1'b1, '0, '0, '0, 2'b00);
         rd(ADDR_TIMER, 8'h01);
      end
      wr(6'h00, 8'h28, 1'b1);
      wr(ADDR_TIMER, 8'h00, 1'b0);
      pin_pulse();
      rd(ADDR_TIMER, 8'h01);
      wr(6'h00, 8'h38, 1'b1);
      pin_pulse();
      rd(ADDR_TIMER, 8'h02);
      wr(6'h00, 8'h08, 1'b1);
      wdt_en <= 1'b1;
      repeat (2) begin
         @(posedge clk);
         wdt_tick <= 1'b1;
         @(posedge clk);
         wdt_tick <= 1'b0;
         @(negedge clk);
         chk(10'h001, {9'h000, wdt_rst});
      end
      @(posedge clk);
      wdt_en <= 1'b0;
      @(negedge clk);
      chk(10'h040, {2'h0, irq & 8'h40});
      chk(10'h000, {9'h000, status[4]});
      i_core.req(1'b0, '0, '0, '0, 2'b01);
      @(negedge clk);
      chk(10'h018, {2'h0, status & 8'h18});
      i_core.req(1'b0, '0, '0, '0, 2'b10);
      @(negedge clk);
      chk(10'h210, {sleeping, 1'b0, status & 8'h18});
      @(posedge clk);
      pins <= 8'h0C;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(10'h001, {9'h000, status[7]});
      wr(ADDR_IRQ, 8'hB8, 1'b0);
      rd(ADDR_IRQ, 8'h00);
      @(posedge clk);
      rst_sel <= 1'b1;
      pins <= 8'h00;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(10'h218, {pin_rst, 1'b0, status});
      chk(10'h03F, {2'h0, mode});
      stop_test();
   end
endmodule // tb_top
